// ---- wwd_pkg.sv ----
// Purpose: constants shared by the windowed watchdog and rail reset logic
// Assumes: 25 MHz system clock
// Notes:   periods are counted in timebase ticks of one prescaled enable; the drop filter counts clock cycles
package wwd_pkg;
    // ------------------------------------------------------------------
    // clock and timebase
    // ------------------------------------------------------------------
    localparam int unsigned CLK_HZ        = 25000000;
    localparam int unsigned TICK_US       = 100;
    localparam int unsigned TICK_CYC      = (CLK_HZ / 1000000) * TICK_US;
    // base timeout, 202 ms typical with a 10 nF timing capacitor
    localparam int unsigned BASE_MS       = 202;
    localparam int unsigned BASE_TICKS    = (BASE_MS * 1000) / TICK_US;
    // per-rail power-good drop filter
    localparam int unsigned GLITCH_US     = 100;
    localparam int unsigned GLITCH_CYC    = (CLK_HZ / 1000000) * GLITCH_US;
    // window multipliers and rail count
    localparam int unsigned LOWER_DIV     = 4;
    localparam int unsigned UPPER_KICK    = 8;
    localparam int unsigned UPPER_TMO     = 64;
    localparam int unsigned NUM_RAILS     = 4;
    // ------------------------------------------------------------------
    // watchdog states
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        WWD_RESET = 2'b00,
        WWD_LOWER = 2'b01,
        WWD_UPPER = 2'b10
    } wwd_state_t;
endpackage : wwd_pkg

// ---- wwd_rail.sv ----
// Purpose: one rail reset channel with drop filter and release delay
// Assumes: rail_good already synchronised to clk_sys
// Notes:   release delay counts timebase ticks
`timescale 1ns/10ps
module wwd_rail #(
    parameter int unsigned BASE_TICKS = wwd_pkg::BASE_TICKS,
    parameter int unsigned GLITCH_CYC = wwd_pkg::GLITCH_CYC
) (
    input  wire logic clk_sys,
    input  wire logic rst,
    input  wire logic tick,
    input  wire logic enable,
    input  wire logic good,
    output logic      reset_n
);
    logic [31:0] drop_ff, nxt_drop;
    logic [31:0] hold_ff, nxt_hold;
    logic        rst_n_ff, nxt_rst_n;

    always_comb begin
        nxt_drop  = drop_ff;
        nxt_hold  = hold_ff;
        nxt_rst_n = rst_n_ff;
        if (!enable) begin
            nxt_rst_n = 1'b0;
            nxt_drop  = '0;
            nxt_hold  = '0;
        end else if (!good) begin
            nxt_hold = '0;
            if (drop_ff >= GLITCH_CYC) begin
                nxt_rst_n = 1'b0;
            end else begin
                nxt_drop = drop_ff + 32'h1;
            end
        end else begin
            nxt_drop = '0;
            if (!rst_n_ff && tick) begin
                // short dips leave a released output untouched
                if (hold_ff + 32'h1 >= BASE_TICKS) begin
                    nxt_rst_n = 1'b1;
                end else begin
                    nxt_hold = hold_ff + 32'h1;
                end
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            drop_ff  <= '0;
            hold_ff  <= '0;
            rst_n_ff <= 1'b0;
        end else begin
            drop_ff  <= nxt_drop;
            hold_ff  <= nxt_hold;
            rst_n_ff <= nxt_rst_n;
        end
    end

    assign reset_n = rst_n_ff;

    disabled_low_a: assert property (@(posedge clk_sys) disable iff (rst)
        !enable |=> !rst_n_ff) else $error("disabled rail released");
    glitch_filter_a: assert property (@(posedge clk_sys) disable iff (rst)
        (enable && rst_n_ff && $fell(good)) |=> rst_n_ff)
        else $error("rail reset on first low cycle");
endmodule : wwd_rail

// ---- wwd_top.sv ----
// Purpose: windowed watchdog with per-rail reset outputs
// Assumes: kick and rail inputs are asynchronous pins
// Notes:   watchdog and release periods share one prescaled timebase; the drop filter counts clk_sys cycles
// Summary of operation
// - only kick falling edges count
// - timeout drives reset low one period
// - power-up starts in timeout with reset low
// - early kick is a failure, reset asserted
// - base timeout is a parameter, 202 ms
// - lower window is quarter of base period
// - eight periods allowed after a valid kick
// - sixty-four periods allowed after a timeout
// - late kick restarts lower window, no reset
// - rail release delay equals base period
// - rail low over 100 us asserts reset
// - rail released after good for base period
// - disabled rails hold their reset low
`timescale 1ns/10ps
module wwd_top #(
    parameter int unsigned BASE_TICKS = wwd_pkg::BASE_TICKS,
    parameter int unsigned TICK_CYC   = wwd_pkg::TICK_CYC,
    parameter int unsigned GLITCH_CYC = wwd_pkg::GLITCH_CYC
) (
    input  wire logic                          clk_sys,
    input  wire logic                          rst,
    input  wire logic                          watchdog_kick_in,
    input  wire logic [wwd_pkg::NUM_RAILS-1:0] rail_good,
    input  wire logic [wwd_pkg::NUM_RAILS-1:0] rail_enable,
    output logic                               watchdog_reset_out_n,
    output logic [wwd_pkg::NUM_RAILS-1:0]      rail_reset_n
);
    // ------------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------------
    logic       kick_s1_ff, kick_s2_ff, kick_d_ff;
    logic [wwd_pkg::NUM_RAILS-1:0] good_s1_ff, good_s2_ff;
    logic [wwd_pkg::NUM_RAILS-1:0] en_s1_ff, en_s2_ff;
    logic       kick_fall;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            kick_s1_ff <= 1'b1;
            kick_s2_ff <= 1'b1;
            kick_d_ff  <= 1'b1;
            good_s1_ff <= '0;
            good_s2_ff <= '0;
            en_s1_ff   <= '0;
            en_s2_ff   <= '0;
        end else begin
            kick_s1_ff <= watchdog_kick_in;
            kick_s2_ff <= kick_s1_ff;
            kick_d_ff  <= kick_s2_ff;
            good_s1_ff <= rail_good;
            good_s2_ff <= good_s1_ff;
            en_s1_ff   <= rail_enable;
            en_s2_ff   <= en_s1_ff;
        end
    end

    // edge register idles high like the pin, so reset makes no false fall
    assign kick_fall = kick_d_ff && !kick_s2_ff;

    // ------------------------------------------------------------------
    // timebase prescaler
    // ------------------------------------------------------------------
    // one shared tick keeps watchdog and rail periods in step
    logic [31:0] pre_ff, nxt_pre;
    logic        tick_ff, nxt_tick;

    always_comb begin
        nxt_tick = 1'b0;
        nxt_pre  = pre_ff + 32'h1;
        if (pre_ff >= TICK_CYC - 1) begin
            nxt_pre  = '0;
            nxt_tick = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pre_ff  <= '0;
            tick_ff <= 1'b0;
        end else begin
            pre_ff  <= nxt_pre;
            tick_ff <= nxt_tick;
        end
    end

    // ------------------------------------------------------------------
    // watchdog state machine
    // ------------------------------------------------------------------
    localparam int unsigned LOWER_TICKS = BASE_TICKS / wwd_pkg::LOWER_DIV;
    localparam int unsigned KICK_TICKS  = BASE_TICKS * wwd_pkg::UPPER_KICK;
    localparam int unsigned TMO_TICKS   = BASE_TICKS * wwd_pkg::UPPER_TMO;

    wwd_pkg::wwd_state_t st_ff, nxt_st;
    logic [31:0] cnt_ff, nxt_cnt;
    logic        after_tmo_ff, nxt_after_tmo;
    logic        wdo_ff, nxt_wdo;
    logic [31:0] limit;

    // upper window depends on whether the last event was a kick or timeout
    assign limit = after_tmo_ff ? TMO_TICKS : KICK_TICKS;

    always_comb begin
        nxt_st        = st_ff;
        nxt_cnt       = cnt_ff;
        nxt_after_tmo = after_tmo_ff;
        nxt_wdo       = wdo_ff;
        unique case (st_ff)
            wwd_pkg::WWD_RESET: begin
                // kicks are ignored while the reset pulse runs
                if (tick_ff) begin
                    nxt_cnt = cnt_ff + 32'h1;
                    if (cnt_ff + 32'h1 >= BASE_TICKS) begin
                        nxt_st        = wwd_pkg::WWD_LOWER;
                        nxt_cnt       = '0;
                        nxt_wdo       = 1'b1;
                        nxt_after_tmo = 1'b1;
                    end
                end
            end
            wwd_pkg::WWD_LOWER: begin
                // an early kick costs a full reset pulse, not a restart
                if (kick_fall) begin
                    nxt_st  = wwd_pkg::WWD_RESET;
                    nxt_cnt = '0;
                    nxt_wdo = 1'b0;
                end else if (tick_ff) begin
                    nxt_cnt = cnt_ff + 32'h1;
                    if (cnt_ff + 32'h1 >= LOWER_TICKS) begin
                        nxt_st = wwd_pkg::WWD_UPPER;
                    end
                end
            end
            wwd_pkg::WWD_UPPER: begin
                if (kick_fall) begin
                    nxt_st        = wwd_pkg::WWD_LOWER;
                    nxt_cnt       = '0;
                    nxt_after_tmo = 1'b0;
                end else if (tick_ff) begin
                    nxt_cnt = cnt_ff + 32'h1;
                    // total count spans lower window plus the rest
                    if (cnt_ff + 32'h1 >= limit) begin
                        nxt_st  = wwd_pkg::WWD_RESET;
                        nxt_cnt = '0;
                        nxt_wdo = 1'b0;
                    end
                end
            end
            default: begin
                nxt_st  = wwd_pkg::WWD_RESET;
                nxt_cnt = '0;
                nxt_wdo = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_ff        <= wwd_pkg::WWD_RESET;
            cnt_ff       <= '0;
            after_tmo_ff <= 1'b1;
            wdo_ff       <= 1'b0;
        end else begin
            st_ff        <= nxt_st;
            cnt_ff       <= nxt_cnt;
            after_tmo_ff <= nxt_after_tmo;
            wdo_ff       <= nxt_wdo;
        end
    end

    assign watchdog_reset_out_n = wdo_ff;

    // ------------------------------------------------------------------
    // rail reset channels
    // ------------------------------------------------------------------
    // rails share the watchdog tick, so their release delay tracks the base period
    for (genvar i = 0; i < wwd_pkg::NUM_RAILS; i++) begin : g_rail
        wwd_rail #(
            .BASE_TICKS (BASE_TICKS),
            .GLITCH_CYC (GLITCH_CYC)
        ) u_rail (
            .clk_sys (clk_sys),
            .rst     (rst),
            .tick    (tick_ff),
            .enable  (en_s2_ff[i]),
            .good    (good_s2_ff[i]),
            .reset_n (rail_reset_n[i])
        );
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    // these watch internal state; rail checks sit beside the rail logic
    early_kick_a: assert property (@(posedge clk_sys) disable iff (rst)
        (st_ff == wwd_pkg::WWD_LOWER && kick_fall) |=> !wdo_ff)
        else $error("early kick did not reset");
    late_kick_a: assert property (@(posedge clk_sys) disable iff (rst)
        (st_ff == wwd_pkg::WWD_UPPER && kick_fall) |=>
        (wdo_ff && st_ff == wwd_pkg::WWD_LOWER && cnt_ff == 0))
        else $error("late kick mishandled");
    reset_len_a: assert property (@(posedge clk_sys) disable iff (rst)
        !wdo_ff |-> (cnt_ff < BASE_TICKS))
        else $error("reset pulse too long");
    reset_state_a: assert property (@(posedge clk_sys) disable iff (rst)
        (wdo_ff == (st_ff != wwd_pkg::WWD_RESET)))
        else $error("reset output and state disagree");
    lower_bound_a: assert property (@(posedge clk_sys) disable iff (rst)
        (st_ff == wwd_pkg::WWD_LOWER) |-> cnt_ff < LOWER_TICKS)
        else $error("lower window overran");
    upper_bound_a: assert property (@(posedge clk_sys) disable iff (rst)
        (st_ff == wwd_pkg::WWD_UPPER) |-> cnt_ff < limit)
        else $error("upper window overran");
    tick_gap_a: assert property (@(posedge clk_sys) disable iff (rst)
        tick_ff |=> !tick_ff) else $error("timebase ticks adjacent");
    // outside a fall or a tick the upper window must not move
    fall_only_a: assert property (@(posedge clk_sys) disable iff (rst)
        (st_ff == wwd_pkg::WWD_UPPER && !kick_fall && !tick_ff) |=> st_ff == wwd_pkg::WWD_UPPER)
        else $error("state left without a falling edge");
endmodule : wwd_top

// ---- wwd_host.sv ----
// Purpose: host model that kicks the watchdog when asked
// Assumes: a request is raised only while busy is low
// Notes:   kick idles high, so only requested pulses make falling edges
`timescale 1ns/10ps
module wwd_host (
    input  wire logic       clk_sys,
    input  wire logic       kick_req,
    input  wire logic [7:0] low_len,
    output logic            kick_n,
    output logic            busy
);
    int cnt = 0;
    // four idle-high cycles after each pulse keep kicks resolvable
    always @(posedge clk_sys) begin
        if (kick_req && cnt == 0)
            cnt <= int'(low_len) + 4;
        else if (cnt > 0)
            cnt <= cnt - 1;
    end
    assign kick_n = !(cnt > 4);
    assign busy   = (cnt != 0) || kick_req;
endmodule : wwd_host

// ---- windowed_watchdog_reset_tb.sv ----
// Purpose: self-checking bench for the windowed watchdog and rail resets
// Assumes: shortened sim parameters, 40 ns clock
// Notes:   watchdog falls are checked against queued notes
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin n_fail++; \
    $display("mismatch %s expected %0h seen %0h", nm, exp, got); end end
module windowed_watchdog_reset_tb;
    localparam int BT = 8;
    localparam int TC = 4;
    localparam int GC = 5;
    localparam int BC = BT * TC;
    typedef struct { bit from_kick; int dly; int tol; } wwd_note_t;
    logic                          clk_sys = 1'b0;
    logic                          rst = 1'b1;
    logic [wwd_pkg::NUM_RAILS-1:0] rail_good = 4'hf;
    logic [wwd_pkg::NUM_RAILS-1:0] rail_enable = 4'hf;
    logic [wwd_pkg::NUM_RAILS-1:0] rail_rst_n;
    logic                          kick_req = 1'b0;
    logic [7:0]                    low_len = 8'h04;
    logic [7:0]                    lfsr = 8'h51;
    logic                          kick_n, busy, wdo_n;
    logic                          prev_w = 1'b0;
    logic                          prev_k = 1'b1;
    int                            n_fail = 0, tests_run = 0;
    int                            cyc = 0, t_rise = 0, t_kick = 0, t_low = 0;
    wwd_note_t                     notes[$];
    always #20 clk_sys = ~clk_sys;
    wwd_top #(.BASE_TICKS(BT), .TICK_CYC(TC), .GLITCH_CYC(GC)) wwd_top_inst (
        .clk_sys(clk_sys), .rst(rst), .watchdog_kick_in(kick_n),
        .rail_good(rail_good), .rail_enable(rail_enable),
        .watchdog_reset_out_n(wdo_n), .rail_reset_n(rail_rst_n));
    wwd_host wwd_host_inst (.clk_sys(clk_sys), .kick_req(kick_req), .low_len(low_len),
        .kick_n(kick_n), .busy(busy));
    function automatic logic [7:0] lfsr_next(logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr_next
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : print_verdict
    task automatic step(int n);
        repeat (n) @(posedge clk_sys);
    endtask : step
    task automatic wait_wdo(logic v, int b);
        while (wdo_n !== v && b > 0) begin
            @(posedge clk_sys);
            b--;
        end
        if (wdo_n !== v) begin
            `CHK("wdo level", v, wdo_n)
            print_verdict();
        end
    endtask : wait_wdo
    task automatic kick(logic [7:0] len);
        int b = 200;
        while (busy && b > 0) begin
            @(posedge clk_sys);
            b--;
        end
        if (busy) begin
            `CHK("host busy", 1'b0, busy)
            print_verdict();
        end
        low_len <= len;
        kick_req <= 1'b1;
        @(posedge clk_sys);
        kick_req <= 1'b0;
        @(posedge clk_sys);
    endtask : kick
    // ----------------------------------------
    // monitor: times every watchdog edge
    // ----------------------------------------
    always @(posedge clk_sys) begin : monitor
        wwd_note_t n;
        int        d;
        cyc++;
        if (rst) t_low = cyc;
        if (prev_k && !kick_n) t_kick = cyc;
        if (!rst && prev_w && !wdo_n) begin
            if (notes.size() == 0) `CHK("wdo fall expected", 1'b1, 1'b0)
            else begin
                n = notes.pop_front();
                d = cyc - (n.from_kick ? t_kick : t_rise);
                `CHK("wdo fall time", 1'b1, d >= n.dly - n.tol && d <= n.dly + n.tol)
            end
            t_low = cyc;
        end
        if (!rst && !prev_w && wdo_n) begin
            d = cyc - t_low;
            `CHK("wdo low length", 1'b1, d >= BC - 2 && d <= BC + TC + 4)
            t_rise = cyc;
        end
        prev_w = wdo_n;
        prev_k = kick_n;
    end
    // ----------------------------------------
    // stimulus
    // ----------------------------------------
    initial begin
        step(20);
        rst <= 1'b0;
        wait_wdo(1'b1, BC + 40);
        notes.push_back('{1'b0, 64 * BC, TC + 4});
        wait_wdo(1'b0, 64 * BC + 40);
        wait_wdo(1'b1, BC + 40);
        $display("test timeout_window done");
        notes.push_back('{1'b1, 4, 3});
        kick(8'h04);
        wait_wdo(1'b0, 20);
        wait_wdo(1'b1, BC + 40);
        $display("test early_kick done");
        step(20);
        kick(8'h04);
        repeat (4) begin
            lfsr = lfsr_next(lfsr);
            step(24 + int'(lfsr[6:0]));
            kick(8'h03 + {5'h00, lfsr[2:0]});
        end
        // one long pulse must count once, from its falling edge
        notes.push_back('{1'b1, 8 * BC + 4, TC + 4});
        kick(8'h64);
        wait_wdo(1'b0, 8 * BC + 40);
        wait_wdo(1'b1, BC + 40);
        $display("test late_kicks done");
        `CHK("rails released", 4'hf, rail_rst_n)
        rail_good <= 4'he;
        step(3);
        rail_good <= 4'hf;
        step(20);
        `CHK("short dip", 4'hf, rail_rst_n)
        rail_good <= 4'hd;
        step(GC + 12);
        `CHK("long dip", 1'b0, rail_rst_n[1])
        rail_good <= 4'hf;
        step(BC - 8);
        `CHK("release early", 1'b0, rail_rst_n[1])
        step(TC + 20);
        `CHK("release late", 1'b1, rail_rst_n[1])
        repeat (4) begin
            lfsr = lfsr_next(lfsr);
            rail_enable <= lfsr[3:0];
            step(8);
            `CHK("disabled rails", 4'h0, rail_rst_n & ~rail_enable)
        end
        $display("test rails done");
        `CHK("notes left", 0, notes.size())
        print_verdict();
    end
endmodule : windowed_watchdog_reset_tb
